// *** rtl/bsc_exec.sv ***
// Execute stage for bit-skip, call and clear instructions
`timescale 1ns/1ps

module bsc_exec
   import bsc_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   // Fetched instruction and core state, same clock
   input  wire logic [11:0] instr,
   input  wire logic        instr_valid,
   input  wire logic [7:0]  file_rd_data,
   input  wire logic [7:0]  status_in,
   // File register access
   output logic [4:0]       file_addr,
   output logic             file_wr,
   output logic [7:0]       file_wr_data,
   // Accumulator and zero flag updates
   output logic             acc_wr,
   output logic [7:0]       acc_wr_data,
   output logic             zero_set,
   // Program counter and stack
   output logic [10:0]      program_counter,
   output logic             stack_push,
   output logic [10:0]      stack_head,
   // Cycle flags
   output logic             flush,
   output logic             busy
);

   typedef struct packed {
      logic [1:0]  rst_sync;
      logic [4:0]  file_addr;
      logic        file_wr;
      logic        acc_wr;
      logic        zero_set;
      logic [10:0] pc;
      logic        push;
      logic [10:0] head;
      logic        flush;
      logic        busy;
      logic        kill;
      logic        hold;
   } bsc_state_t;

   bsc_state_t s_reg;
   bsc_state_t s_next;
   bsc_op_t    op;
   logic       rst_int_b;

   assign rst_int_b = s_reg.rst_sync[1];

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   bsc_decode u_dec (
      .instr (instr),
      .op    (op)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_next          = s_reg;
      s_next.rst_sync = {s_reg.rst_sync[0], 1'b1};
      s_next.file_wr  = 1'b0;
      s_next.acc_wr   = 1'b0;
      s_next.zero_set = 1'b0;
      s_next.push     = 1'b0;
      s_next.flush    = 1'b0;
      s_next.busy     = 1'b0;
      // Pending discard survives idle cycles, so a gap never lets the slot word run
      if (instr_valid) begin
         s_next.kill = 1'b0;
         s_next.hold = 1'b0;
         // Word after a taken skip or a call executes as a no-op
         if (s_reg.kill) begin
            // After a call the counter already names the target, so it stays put
            if (!s_reg.hold) begin
               s_next.pc = s_reg.pc + 11'd1;
            end
         end else begin
            s_next.pc = s_reg.pc + 11'd1;
            case (op)
               BSC_SKIP_SET: begin
                  s_next.file_addr = instr[FILE_HI:FILE_LO];
                  if (file_rd_data[instr[BIT_SEL_HI:BIT_SEL_LO]]) begin
                     s_next.kill  = 1'b1;
                     s_next.flush = 1'b1;
                     s_next.busy  = 1'b1;
                  end
               end
               BSC_CALL: begin
                  s_next.push = 1'b1;
                  s_next.head = s_reg.pc + 11'd1;
                  s_next.pc   = {status_in[PAGE_HI:PAGE_LO], 1'b0,
                                 instr[7:0]};
                  // Flags untouched; second cycle spent flushing prefetch
                  s_next.kill  = 1'b1;
                  s_next.flush = 1'b1;
                  s_next.busy  = 1'b1;
                  s_next.hold  = 1'b1;
               end
               BSC_CLR_FILE: begin
                  s_next.file_addr = instr[FILE_HI:FILE_LO];
                  s_next.file_wr   = 1'b1;
                  s_next.zero_set  = 1'b1;
               end
               BSC_CLR_ACC: begin
                  s_next.acc_wr   = 1'b1;
                  s_next.zero_set = 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else if (!rst_int_b) begin
         s_reg          <= '0;
         s_reg.rst_sync <= s_next.rst_sync;
         s_reg.pc       <= PC_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign file_addr       = s_reg.file_addr;
   assign file_wr         = s_reg.file_wr;
   assign file_wr_data    = DATA_CLEAR;
   assign acc_wr          = s_reg.acc_wr;
   assign acc_wr_data     = DATA_CLEAR;
   assign zero_set        = s_reg.zero_set;
   assign program_counter = s_reg.pc;
   assign stack_push      = s_reg.push;
   assign stack_head      = s_reg.head;
   assign flush           = s_reg.flush;
   assign busy            = s_reg.busy;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_int_b);

   skip_decode_a: assert property (
      instr_valid && !s_reg.kill && instr[11:8] == 4'h7 |=> file_addr == $past(instr[4:0]))
      else $error("skip address not captured");
   skip_taken_a: assert property (
      instr_valid && !s_reg.kill && op == BSC_SKIP_SET
      && file_rd_data[instr[7:5]] |=> flush && busy)
      else $error("taken skip did not flush");
   skip_one_cycle_a: assert property (
      instr_valid && !s_reg.kill && op == BSC_SKIP_SET
      && !file_rd_data[instr[7:5]] |=> !flush)
      else $error("untaken skip flushed");
   call_push_a: assert property (
      instr_valid && !s_reg.kill && op == BSC_CALL
      |=> stack_push && stack_head == $past(program_counter) + 11'd1)
      else $error("call pushed wrong address");
   call_low_a: assert property (
      instr_valid && !s_reg.kill && op == BSC_CALL
      |=> program_counter[7:0] == $past(instr[7:0]))
      else $error("call low bits wrong");
   call_page_a: assert property (
      instr_valid && !s_reg.kill && op == BSC_CALL
      |=> program_counter[10:9] == $past(status_in[6:5]) && !program_counter[8])
      else $error("call page bits wrong");
   call_flags_a: assert property (
      instr_valid && !s_reg.kill && op == BSC_CALL
      |=> !zero_set ##1 (!stack_push && !file_wr && !acc_wr))
      else $error("call touched flags or no-op slot");
   clr_file_a: assert property (
      instr_valid && !s_reg.kill && instr[11:5] == 7'h03
      |=> file_wr && zero_set && file_wr_data == 8'h00)
      else $error("file clear failed");
   clr_acc_a: assert property (
      instr_valid && !s_reg.kill && instr == 12'h040 |=> acc_wr && zero_set)
      else $error("accumulator clear failed");
   clr_exact_a: assert property (
      acc_wr |-> $past(instr) == 12'h040)
      else $error("accumulator clear on wrong word");
   slot_hold_a: assert property (
      instr_valid && s_reg.kill && s_reg.hold |=> program_counter == $past(program_counter))
      else $error("call slot moved the counter");
   slot_noop_a: assert property (
      instr_valid && s_reg.kill |=> !file_wr && !acc_wr && !zero_set && !stack_push && !flush)
      else $error("discarded word had an effect");
   kill_keep_a: assert property (
      s_reg.kill && !instr_valid |=> s_reg.kill)
      else $error("skip lost across an idle cycle");

   skip_cov: cover property (flush && !stack_push);
   call_cov: cover property (stack_push);
   clr_file_cov: cover property (file_wr);
   clr_acc_cov: cover property (acc_wr);
   call_slot_cov: cover property (s_reg.hold && instr_valid);

endmodule

// *** rtl/bsc_pkg.sv ***
// Constants and types shared by the instruction execute block
package bsc_pkg;

   // ------------------------------------------------------------
   // Instruction encodings
   // ------------------------------------------------------------
   localparam logic [3:0]  OP_SKIP_SET   = 4'h7;
   localparam logic [3:0]  OP_CALL       = 4'h9;
   localparam logic [6:0]  OP_CLR_FILE   = 7'h03;
   localparam logic [11:0] OP_CLR_ACC    = 12'h040;
   localparam logic [11:0] OP_NOP        = 12'h000;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int OPC_HI       = 11;
   localparam int OPC_LO       = 8;
   localparam int BIT_SEL_HI   = 7;
   localparam int BIT_SEL_LO   = 5;
   localparam int FILE_HI      = 4;
   localparam int FILE_LO      = 0;
   localparam int CLR_OPC_LO   = 5;
   localparam int PAGE_HI      = 6;
   localparam int PAGE_LO      = 5;

   // ------------------------------------------------------------
   // Widths and reset values
   // ------------------------------------------------------------
   localparam int PC_W         = 11;
   localparam logic [10:0] PC_RESET   = 11'h000;
   localparam logic [7:0]  DATA_CLEAR = 8'h00;

   typedef enum logic [2:0] {
      BSC_OTHER,
      BSC_SKIP_SET,
      BSC_CALL,
      BSC_CLR_FILE,
      BSC_CLR_ACC
   } bsc_op_t;

endpackage

// *** rtl/bsc_decode.sv ***
// Combinational decoder for the four supported instruction words
`timescale 1ns/1ps
module bsc_decode
   import bsc_pkg::*;
(
   // Instruction word
   input  wire logic [11:0] instr,
   // Decoded class
   output bsc_op_t          op
);

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   always_comb begin
      op = BSC_OTHER;
      if (instr[OPC_HI:OPC_LO] == OP_SKIP_SET) begin
         op = BSC_SKIP_SET;
      end else if (instr[OPC_HI:OPC_LO] == OP_CALL) begin
         op = BSC_CALL;
      end else if (instr[OPC_HI:CLR_OPC_LO] == OP_CLR_FILE) begin
         op = BSC_CLR_FILE;
      end else if (instr == OP_CLR_ACC) begin
         // Whole word compared: the 0000 group holds many control codes
         op = BSC_CLR_ACC;
      end
   end

endmodule

// *** sim/bsc_prog_mem.sv ***
// Program memory model that supplies one instruction word per counter value
`timescale 1ns/1ps
module bsc_prog_mem
   import bsc_pkg::*;
(
   // Fetch address
   input  wire logic [10:0] program_counter,
   // Fetched word
   output logic [11:0]      instr
);
   logic [11:0] mem [0:2047];
   // Unloaded places read all ones so a stale word is never a clear or call
   initial begin
      for (int i = 0; i < 2048; i++) begin
         mem[i] = 12'hfff;
      end
   end
   // Combinational fetch, word ready in the same cycle as the address
   assign instr = mem[program_counter];
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the skip, call and clear execute block
`timescale 1ns/1ps
module tb
   import bsc_pkg::*;
;
   typedef struct {
      logic [11:0] w;
      logic [7:0]  rd;
      logic [7:0]  st;
      logic [10:0] pc;
      logic [5:0]  fl;
      logic [4:0]  fa;
      logic [10:0] sh;
   } bsc_row_t;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        sys_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        instr_valid = 1'b0;
   logic [7:0]  file_rd_data = 8'h00;
   logic [7:0]  status_in = 8'h00;
   logic [11:0] instr;
   logic [4:0]  file_addr;
   logic        file_wr, acc_wr, zero_set, stack_push, flush, busy;
   logic [7:0]  file_wr_data, acc_wr_data;
   logic [10:0] program_counter, stack_head;
   int          failures = 0;
   int          checks = 0;
   int          cycles = 0;
   bsc_row_t    rows [13];
   always #5 sys_clk = ~sys_clk;
   bsc_prog_mem i_bsc_prog_mem (.program_counter(program_counter), .instr(instr));
   bsc_exec i_bsc_exec (.sys_clk(sys_clk), .rst_b(rst_b), .instr(instr),
      .instr_valid(instr_valid), .file_rd_data(file_rd_data), .status_in(status_in),
      .file_addr(file_addr), .file_wr(file_wr), .file_wr_data(file_wr_data),
      .acc_wr(acc_wr), .acc_wr_data(acc_wr_data), .zero_set(zero_set),
      .program_counter(program_counter), .stack_push(stack_push),
      .stack_head(stack_head), .flush(flush), .busy(busy));
   // ------------------------------------------------------------
   // Compare and closing tasks
   // ------------------------------------------------------------
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flags(input logic [5:0] exp);
      checks++;
      if ({file_wr, acc_wr, zero_set, stack_push, flush, busy} !== exp) begin
         failures++;
         $display("Error at %0t: flags %h expected %h", $time,
                  {file_wr, acc_wr, zero_set, stack_push, flush, busy}, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Generous ceiling, the whole run needs about 30 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         test_done();
      end
   end
   // ------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------
   initial begin
      // Word, file bit data, status, then counter, flags, file address, stack head
      rows = '{
         '{12'h040, 8'h00, 8'h00, 11'h001, 6'b011000, 5'h00, 11'h000},
         '{12'h065, 8'h00, 8'h00, 11'h002, 6'b101000, 5'h05, 11'h000},
         '{12'h7e3, 8'h80, 8'h00, 11'h003, 6'b000011, 5'h03, 11'h000},
         '{12'h040, 8'h00, 8'h00, 11'h004, 6'b000000, 5'h03, 11'h000},
         '{12'h7e3, 8'h7f, 8'h00, 11'h005, 6'b000000, 5'h03, 11'h000},
         '{12'h9ab, 8'h00, 8'h40, 11'h4ab, 6'b000111, 5'h03, 11'h006},
         '{12'h065, 8'h00, 8'h00, 11'h4ab, 6'b000000, 5'h03, 11'h006},
         '{12'h9ff, 8'h00, 8'h60, 11'h6ff, 6'b000111, 5'h03, 11'h4ac},
         '{12'h000, 8'h00, 8'h00, 11'h6ff, 6'b000000, 5'h03, 11'h4ac},
         '{12'h041, 8'h00, 8'h00, 11'h700, 6'b000000, 5'h03, 11'h4ac},
         '{12'h640, 8'h00, 8'h00, 11'h701, 6'b000000, 5'h03, 11'h4ac},
         '{12'h71f, 8'h01, 8'h00, 11'h702, 6'b000011, 5'h1f, 11'h4ac},
         '{12'h9ab, 8'h00, 8'h00, 11'h703, 6'b000000, 5'h1f, 11'h4ac}};
      repeat (4) @(negedge sys_clk);
      rst_b = 1'b1;
      // Synchroniser needs two edges before the first word may be taken
      repeat (3) @(negedge sys_clk);
      chk_val(16'(program_counter), 16'h0000);
      instr_valid = 1'b1;
      foreach (rows[i]) begin
         i_bsc_prog_mem.mem[program_counter] = rows[i].w;
         file_rd_data = rows[i].rd;
         status_in = rows[i].st;
         @(negedge sys_clk);
         chk_val(16'(program_counter), 16'(rows[i].pc));
         chk_flags(rows[i].fl);
         chk_val(16'(file_addr), 16'(rows[i].fa));
         chk_val(16'(stack_head), 16'(rows[i].sh));
         chk_val({file_wr_data, acc_wr_data}, 16'h0000);
      end
      // Words without valid leave the counter as it was and raise no flags
      instr_valid = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk_val(16'(program_counter), 16'h0703);
      chk_flags(6'b000000);
      // A taken skip still discards the next valid word after an idle cycle
      i_bsc_prog_mem.mem[program_counter] = 12'h7e3;
      file_rd_data = 8'h80;
      instr_valid = 1'b1;
      @(negedge sys_clk);
      chk_flags(6'b000011);
      instr_valid = 1'b0;
      @(negedge sys_clk);
      i_bsc_prog_mem.mem[program_counter] = 12'h040;
      instr_valid = 1'b1;
      @(negedge sys_clk);
      chk_flags(6'b000000);
      chk_val(16'(program_counter), 16'h0705);
      instr_valid = 1'b0;
      // Reset in mid-run clears the counter at once
      rst_b = 1'b0;
      #1;
      chk_val(16'(program_counter), 16'h0000);
      @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk_val(16'(program_counter), 16'h0000);
      i_bsc_prog_mem.mem[0] = 12'h040;
      instr_valid = 1'b1;
      @(negedge sys_clk);
      chk_flags(6'b011000);
      chk_val(16'(program_counter), 16'h0001);
      instr_valid = 1'b0;
      test_done();
   end
endmodule
